// ---- rtl/sdc_consts.vh ----
// Register offsets, field positions, reset values and codes for the clock/sleep block
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH

// Register addresses on the plain register port
`define SDC_MISC_ADDR        8'h12
`define SDC_SLEEP_ADDR       8'h13

// Misc settings register fields
`define SDC_FAST_HI          4
`define SDC_FAST_LO          3
`define SDC_SENSE_BIT        2
`define SDC_SLOW_HI          1
`define SDC_SLOW_LO          0

// Sleep control register fields
`define SDC_SLEEP_EN_BIT     7
`define SDC_SDIV_HI          6
`define SDC_SDIV_LO          3
`define SDC_PIN_STS_BIT      2
`define SDC_PIN_FN_BIT       1
`define SDC_MISS_SEL_BIT     0

// Reset values
`define SDC_FAST_RST         2'h2
`define SDC_SLOW_RST         2'h0
`define SDC_SENSE_RST        1'h0
`define SDC_SDIV_RST         4'h0
`define SDC_PIN_FN_RST       1'h0
`define SDC_MISS_SEL_RST     1'h0

// Fast divider reserved code
`define SDC_FAST_RSVD        2'h3

// Divide ratios (width 11 bits)
`define SDC_RATIO_1          11'h001
`define SDC_RATIO_2          11'h002
`define SDC_RATIO_4          11'h004
`define SDC_RATIO_6          11'h006
`define SDC_RATIO_8          11'h008
`define SDC_RATIO_12         11'h00c
`define SDC_RATIO_16         11'h010
`define SDC_RATIO_64         11'h040
`define SDC_RATIO_128        11'h080
`define SDC_RATIO_256        11'h100
`define SDC_RATIO_1024       11'h400

`endif

// ---- rtl/sdc_divider.v ----
// Glitch-free clock divider counting edges of a sampled base clock
`timescale 1ns/1ns
`include "sdc_consts.vh"

module sdc_divider (
  input  wire        clk,         // System clock
  input  wire        nrst,        // Async reset, active low
  input  wire        cen,         // Clock enable, freezes state when low
  input  wire        base_level,  // Synchronised base clock level
  input  wire        base_tick,   // One-cycle pulse on base rising edge
  input  wire [10:0] ratio,       // Requested divide ratio
  output reg         clk_out      // Divided clock
);

  reg [10:0] cnt;                 // Base edges within current period
  reg [10:0] cur;                 // Ratio in force this period

  ////////////////////////////////////////////////////////////////////////
  // Counter; new ratio only taken at a period boundary, no runt pulses
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt     <= 11'h000;
      cur     <= `SDC_RATIO_1;
      clk_out <= 1'b0;
    end else if (cen) begin
      if (cur == `SDC_RATIO_1) begin
        // Pass-through: follow base, switch on a base edge
        clk_out <= base_level;
        if (base_tick) begin
          cur <= ratio; // [R22]
          cnt <= 11'h000;
        end
      end else if (base_tick) begin
        if (cnt == cur - 11'h001) begin
          // Period boundary: load pending ratio
          cnt     <= 11'h000;
          cur     <= ratio; // [R22]
          clk_out <= (ratio != `SDC_RATIO_1) ? 1'b1 : base_level;
        end else begin
          // High for first half, low for second half
          cnt     <= cnt + 11'h001;
          clk_out <= ((cnt + 11'h001) < {1'b0, cur[10:1]});
        end
      end
    end
  end

endmodule // sdc_divider

// ---- rtl/sdc_sleep_clock.v ----
// Bus clock divider select and sleep mode control with register port
`timescale 1ns/1ns
`include "sdc_consts.vh"

// What this block does
// [R1] Fast field divides base by 2,4,6
// [R2] Base is oscillator if async, else doubled clock
// [R3] Slow field divides base by 2,4,6,8
// [R4] Slow setting during DRAM or sense zero
// [R5] No oscillator: sense bit reads pin level
// [R6] Oscillator attached: sense bit read/write selector
// [R7] Pin-function bit makes pin a sleep request
// [R8] Falling sleep-pin edge enters sleep
// [R9] Software writes one to enable sleep
// [R10] Sleep divides processor clock, gates oscillator
// [R11] Essential logic keeps its clock in sleep
// [R12] Software should halt after setting sleep
// [R13] Sleep divider alone sets processor clock
// [R14] Clearing enable bit leaves sleep
// [R15] Rising pin edge with select zero wakes
// [R16] Interrupt or reset ends sleep
// [R17] Waking restores routing and normal speed
// [R18] Hold request suspends the sleep divider
// [R19] After hold, resume sleep if still enabled
// [R20] Enable is bit seven, resets zero
// [R21] Sleep divider codes 1 to 1024
// [R22] Switching synchronised, only at period boundaries
// [R23] After interrupt stay awake until new request
module sdc_sleep_clock (
  input  wire       clk,                     // System clock, 10 MHz
  input  wire       nrst,                    // Async reset, active low
  input  wire       cen,                     // Clock enable
  input  wire [7:0] addr,                    // Register address
  input  wire [7:0] wdata,                   // Register write data
  input  wire       wr,                      // Write strobe
  input  wire       rd,                      // Read strobe
  output reg  [7:0] rdata,                   // Read data, cycle after rd
  input  wire       bus_oscillator_input,    // Bus oscillator pin
  input  wire       base_double_clock_input, // Base doubled clock pin
  input  wire       bus_osc_attached,        // Strap: oscillator fitted
  input  wire       bus_clock_sync,          // Strap: bus clock synchronised
  input  wire       sleep_pin_n,             // Shared sleep pin, active low
  input  wire       hold_request,            // Hold request, same clock
  input  wire       interrupt_request,       // Interrupt to device, same clock
  input  wire       dram_access,             // System DRAM cycle, same clock
  output wire       system_bus_clock,        // Divided bus clock
  output wire       processor_double_clock,  // Processor doubled clock
  output reg        nonessential_osc,        // Gated oscillator for idle logic
  output reg        essential_osc,           // Ungated oscillator, DMA/int/refresh
  output reg        sleep_active             // Sleep divider in force
);

  ////////////////////////////////////////////////////////////////////////
  // State codes
  localparam [1:0] ST_AWAKE   = 2'h0;        // Normal running
  localparam [1:0] ST_ASLEEP  = 2'h1;        // Sleep divider active
  localparam [1:0] ST_SUSPEND = 2'h2;        // Sleep held off by hold request

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [4:0]  sync1;                         // First synchroniser stage
  reg  [4:0]  sync2;                         // Second synchroniser stage
  reg         osc_prev;                      // Oscillator edge detect
  reg         tclk_prev;                     // Base clock edge detect
  reg         pin_prev;                      // Sleep pin edge detect
  reg  [1:0]  fast_div;                      // Fast divider field
  reg  [1:0]  slow_div;                      // Slow divider field
  reg         sense_rw;                      // Stored sense bit
  reg         sleep_en;                      // Sleep enable bit
  reg  [3:0]  sleep_div;                     // Sleep divider field
  reg         pin_fn;                        // Pin acts as sleep input
  reg         miss_sel;                      // Sleep/miss select bit
  reg         hw_sleep;                      // Hardware sleep request
  reg  [1:0]  state;                         // Sleep state
  reg  [1:0]  next_state;                    // Next sleep state
  wire        osc_s;                         // Synced oscillator
  wire        tclk_s;                        // Synced base clock
  wire        attached_s;                    // Synced oscillator strap
  wire        sync_s;                        // Synced sync strap
  wire        pin_s;                         // Synced sleep pin
  wire        osc_tick;                      // Oscillator rising edge
  wire        tclk_tick;                     // Base clock rising edge
  wire        pin_fall;                      // Sleep pin falling edge
  wire        pin_rise;                      // Sleep pin rising edge
  wire        sense_eff;                     // Effective sense bit
  wire        bus_level;                     // Chosen bus base level
  wire        bus_tick;                      // Chosen bus base edge
  wire        sleep_want;                    // Any sleep request pending
  wire        sw_set;                        // Software writes enable one
  wire        sw_write;                      // Write to sleep register
  wire [10:0] bus_ratio;                     // Bus clock ratio
  wire [10:0] cpu_ratio;                     // Processor clock ratio
  wire [7:0]  misc_rd;                       // Misc register read value
  wire [7:0]  sleep_rd;                      // Sleep register read value

  ////////////////////////////////////////////////////////////////////////
  // Functions
  // Bus divider code to ratio, code 3 gives 8; reserved fast code mapped to 6 by the caller
  function [10:0] bus_div_ratio;
    input [1:0] code;
    begin
      case (code)
        2'h0:    bus_div_ratio = `SDC_RATIO_2;
        2'h1:    bus_div_ratio = `SDC_RATIO_4;
        2'h2:    bus_div_ratio = `SDC_RATIO_6;
        default: bus_div_ratio = `SDC_RATIO_8;
      endcase
    end
  endfunction

  // Sleep divider code to ratio, reserved codes divide by 1
  function [10:0] sleep_div_ratio;
    input [3:0] code;
    begin
      case (code)
        4'h1:    sleep_div_ratio = `SDC_RATIO_4;
        4'h2:    sleep_div_ratio = `SDC_RATIO_8;
        4'h3:    sleep_div_ratio = `SDC_RATIO_12;
        4'h4:    sleep_div_ratio = `SDC_RATIO_16;
        4'h5:    sleep_div_ratio = `SDC_RATIO_64;
        4'h6:    sleep_div_ratio = `SDC_RATIO_128;
        4'h7:    sleep_div_ratio = `SDC_RATIO_256;
        4'h8:    sleep_div_ratio = `SDC_RATIO_1024;
        default: sleep_div_ratio = `SDC_RATIO_1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops before any use
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
    end else if (cen) begin
      sync1 <= {sleep_pin_n, bus_clock_sync, bus_osc_attached,
                base_double_clock_input, bus_oscillator_input};
      sync2 <= sync1;
    end
  end

  assign osc_s      = sync2[0];
  assign tclk_s     = sync2[1];
  assign attached_s = sync2[2];
  assign sync_s     = sync2[3];
  assign pin_s      = sync2[4];

  // Edge detect registers on second stage only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_prev  <= 1'b1;
      tclk_prev <= 1'b1;
      pin_prev  <= 1'b1;
    end else if (cen) begin
      osc_prev  <= osc_s;
      tclk_prev <= tclk_s;
      pin_prev  <= pin_s;
    end
  end

  assign osc_tick  = osc_s & ~osc_prev;
  assign tclk_tick = tclk_s & ~tclk_prev;
  assign pin_fall  = pin_fn & pin_prev & ~pin_s;             // [R7] [R8]
  assign pin_rise  = pin_fn & ~miss_sel & ~pin_prev & pin_s; // [R7] [R15]

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  assign sw_write = wr & (addr == `SDC_SLEEP_ADDR);
  assign sw_set   = sw_write & wdata[`SDC_SLEEP_EN_BIT];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fast_div  <= `SDC_FAST_RST;
      slow_div  <= `SDC_SLOW_RST;
      sense_rw  <= `SDC_SENSE_RST;
      sleep_en  <= 1'b0;                     // [R20]
      sleep_div <= `SDC_SDIV_RST;
      pin_fn    <= `SDC_PIN_FN_RST;
      miss_sel  <= `SDC_MISS_SEL_RST;
    end else if (cen) begin
      // Misc settings write
      if (wr && addr == `SDC_MISC_ADDR) begin
        fast_div <= wdata[`SDC_FAST_HI:`SDC_FAST_LO];
        slow_div <= wdata[`SDC_SLOW_HI:`SDC_SLOW_LO];
        if (attached_s)
          sense_rw <= wdata[`SDC_SENSE_BIT]; // [R6]
      end
      // Sleep control fields
      if (sw_write) begin
        sleep_div <= wdata[`SDC_SDIV_HI:`SDC_SDIV_LO];
        pin_fn    <= wdata[`SDC_PIN_FN_BIT];
        miss_sel  <= wdata[`SDC_MISS_SEL_BIT];
      end
      // Enable bit; a software set wins over an interrupt clear
      if (sw_set)
        sleep_en <= 1'b1;                    // [R9] [R20]
      else if (sw_write || interrupt_request)
        sleep_en <= 1'b0;                    // [R14] [R16] [R23]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware sleep request latch; new falling edge wins over clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hw_sleep <= 1'b0;                      // [R16]
    end else if (cen) begin
      if (pin_fall)
        hw_sleep <= 1'b1;                    // [R8]
      else if (pin_rise || interrupt_request || !pin_fn)
        hw_sleep <= 1'b0;                    // [R15] [R16] [R23]
    end
  end

  assign sleep_want = sleep_en | hw_sleep;

  ////////////////////////////////////////////////////////////////////////
  // Sleep state machine, advanced on base clock edges
  always @* begin
    next_state = state;
    case (state)
      ST_AWAKE: begin
        if (sleep_want && !hold_request)
          next_state = ST_ASLEEP;
      end
      ST_ASLEEP: begin
        if (!sleep_want)
          next_state = ST_AWAKE;             // [R14] [R17]
        else if (hold_request)
          next_state = ST_SUSPEND;           // [R18]
      end
      ST_SUSPEND: begin
        if (!sleep_want)
          next_state = ST_AWAKE;             // [R19]
        else if (!hold_request)
          next_state = ST_ASLEEP;            // [R19]
      end
      default: next_state = ST_AWAKE;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state        <= ST_AWAKE;
      sleep_active <= 1'b0;
    end else if (cen) begin
      if (tclk_tick) begin
        state        <= next_state;          // [R22]
        sleep_active <= (next_state == ST_ASLEEP);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator routing; essential path never gated
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nonessential_osc <= 1'b0;
      essential_osc    <= 1'b0;
    end else if (cen) begin
      essential_osc    <= osc_s;                   // [R11]
      nonessential_osc <= osc_s & ~sleep_active;   // [R10] [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock source and ratio selection
  assign sense_eff = attached_s ? sense_rw : osc_s;          // [R5] [R6]
  assign bus_level = sync_s ? tclk_s : osc_s;                // [R2]
  assign bus_tick  = sync_s ? tclk_tick : osc_tick;          // [R2]
  assign bus_ratio = (dram_access || !sense_eff) ?
                     bus_div_ratio(slow_div) :               // [R3] [R4]
                     ((fast_div == `SDC_FAST_RSVD) ? `SDC_RATIO_6 :
                      bus_div_ratio(fast_div));              // [R1]
  assign cpu_ratio = sleep_active ? sleep_div_ratio(sleep_div) :
                     `SDC_RATIO_1;                           // [R10] [R13] [R21]

  // System bus clock divider
  sdc_divider u_bus_div (
    .clk        (clk),
    .nrst       (nrst),
    .cen        (cen),
    .base_level (bus_level),
    .base_tick  (bus_tick),
    .ratio      (bus_ratio),
    .clk_out    (system_bus_clock)
  );

  // Processor doubled clock divider
  sdc_divider u_cpu_div (
    .clk        (clk),
    .nrst       (nrst),
    .cen        (cen),
    .base_level (tclk_s),
    .base_tick  (tclk_tick),
    .ratio      (cpu_ratio),
    .clk_out    (processor_double_clock)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register read, data valid only in cycle after strobe
  assign misc_rd  = {3'h0, fast_div, sense_eff, slow_div};   // [R5]
  assign sleep_rd = {sleep_en, sleep_div, pin_s, pin_fn, miss_sel};

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (cen) begin
      if (rd && addr == `SDC_MISC_ADDR)
        rdata <= misc_rd;
      else if (rd && addr == `SDC_SLEEP_ADDR)
        rdata <= sleep_rd;
      else
        rdata <= 8'h00;                      // Unmapped or idle reads zero
    end
  end

endmodule // sdc_sleep_clock

// ---- bench/sdc_osc_model.sv ----
// Oscillator model for the bus oscillator and base doubled clock pins
`timescale 1ns/1ns

module sdc_osc_model #(
  parameter OSC_HALF = 3,  // Bus oscillator half period, clk cycles
  parameter DBL_HALF = 2   // Doubled clock half period, clk cycles
) (
  input  wire clk,         // Bench clock
  input  wire osc_run,     // Oscillator fitted and running
  input  wire stop_level,  // Resting pin level with no oscillator
  output reg  osc_out,     // Bus oscillator pin
  output reg  dbl_out      // Base doubled clock pin
);
  integer oc = 0;  // Oscillator phase count
  integer dc = 0;  // Doubled clock phase count

  initial begin
    osc_out = 1'b0;
    dbl_out = 1'b0;
  end

  // Toggle on each half period; an absent oscillator leaves the pin at its resting level
  always @(posedge clk) begin
    dc <= (dc == DBL_HALF - 1) ? 0 : dc + 1;
    oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
    if (dc == DBL_HALF - 1) dbl_out <= ~dbl_out;
    if (!osc_run) osc_out <= stop_level;
    else if (oc == OSC_HALF - 1) osc_out <= ~osc_out;
  end
endmodule // sdc_osc_model

// ---- bench/sdc_sleep_clock_properties.sv ----
// Port checker for the clock divider and sleep control block
`timescale 1ns/1ns
`include "sdc_consts.vh"

module sdc_sleep_clock_chk (
  input wire       clk,                // System clock
  input wire       nrst,               // Async reset, active low
  input wire       cen,                // Clock enable
  input wire [7:0] addr,               // Register address
  input wire [7:0] wdata,              // Write data
  input wire       wr,                 // Write strobe
  input wire       rd,                 // Read strobe
  input wire [7:0] rdata,              // Read data
  input wire       sleep_pin_n,        // Shared sleep pin
  input wire       hold_request,       // Hold request
  input wire       interrupt_request,  // Interrupt
  input wire       system_bus_clock,   // Divided bus clock
  input wire       nonessential_osc,   // Gated oscillator
  input wire       essential_osc,      // Ungated oscillator
  input wire       sleep_active        // Sleep in force
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  wire rd_take = rd && cen;                                 // Read taken
  wire sw_wr   = cen && wr && addr == `SDC_SLEEP_ADDR;      // Sleep register write
  reg  pin_fn;                                              // Pin acts as sleep input

  // Track the pin-function bit from register writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) pin_fn <= 1'b0;
    else if (sw_wr) pin_fn <= wdata[`SDC_PIN_FN_BIT];
  end

  // Quiet stretch with no hold request, no interrupt and no register write
  sequence quiet8;
    (!hold_request && !interrupt_request && !wr)[*8];
  endsequence
  // No writes and a steady pin
  sequence still8;
    (!wr && $stable(sleep_pin_n))[*8];
  endsequence

  rdata_idle_a: assert property (!$past(rd_take) |-> rdata == 8'h00)
    else $error("read data not zero outside the reply cycle");
  sleep_gate_a: assert property (sleep_active && $past(sleep_active) |-> !nonessential_osc)
    else $error("idle oscillator running in sleep");
  osc_free_a: assert property ($rose(sleep_active) |-> ##[1:12] $changed(essential_osc))
    else $error("essential oscillator stopped in sleep");
  hold_suspend_a: assert property (hold_request[*8] |-> !sleep_active)
    else $error("sleep not suspended by hold");
  sw_entry_a: assert property ((sw_wr && wdata[`SDC_SLEEP_EN_BIT]) ##1 quiet8 |-> ##[0:4] sleep_active)
    else $error("sleep not entered after enable write");
  clear_exit_a: assert property ((sw_wr && wdata[7:0] == 8'h00) ##1 still8 |-> ##[0:4] !sleep_active)
    else $error("sleep not left after enable cleared");
  irq_exit_a: assert property ((interrupt_request && !wr) ##1 still8 |-> ##[0:4] !sleep_active)
    else $error("sleep not left after interrupt");
  pin_entry_a: assert property (($fell(sleep_pin_n) && pin_fn) ##1 quiet8 |-> ##[0:4] sleep_active)
    else $error("sleep not entered on pin fall");
  bus_runt_a: assert property ($rose(system_bus_clock) |-> system_bus_clock[*2])
    else $error("runt high pulse on bus clock");
endmodule // sdc_sleep_clock_chk

bind sdc_sleep_clock sdc_sleep_clock_chk chk_u (.clk(clk), .nrst(nrst), .cen(cen), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .sleep_pin_n(sleep_pin_n), .hold_request(hold_request),
  .interrupt_request(interrupt_request), .system_bus_clock(system_bus_clock),
  .nonessential_osc(nonessential_osc), .essential_osc(essential_osc), .sleep_active(sleep_active));

// ---- bench/testbench.sv ----
// Self-checking bench for the clock divider and sleep control block
`timescale 1ns/1ns
`include "sdc_consts.vh"

module testbench;
  logic       clk, nrst, cen, wr, rd, rd_d, osc_run, stop_lvl, attached, sync, pin_n, hold, irq, dram;
  logic [7:0] addr, wdata;
  wire  [7:0] rdata;                       // Read data
  wire        osc, dbl, sbc, pdc, neo, eso, sleep_enable_bit;
  logic [7:0] exp_q[$];                    // Expected read data, oldest first
  int         n_mismatch = 0, n_checks = 0, cyc = 0, k, ne, et;
  int         rt[9] = '{1, 4, 8, 12, 16, 64, 128, 256, 1024}; // Sleep ratios for codes 0..8
  logic [1:0] f, s;
  logic       b, pe;

  sdc_osc_model osc_u (.clk(clk), .osc_run(osc_run), .stop_level(stop_lvl), .osc_out(osc), .dbl_out(dbl));
  sdc_sleep_clock dut_u (.clk(clk), .nrst(nrst), .cen(cen), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bus_oscillator_input(osc), .base_double_clock_input(dbl), .bus_osc_attached(attached),
    .bus_clock_sync(sync), .sleep_pin_n(pin_n), .hold_request(hold), .interrupt_request(irq),
    .dram_access(dram), .system_bus_clock(sbc), .processor_double_clock(pdc), .nonessential_osc(neo),
    .essential_osc(eso), .sleep_active(sleep_enable_bit));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle count
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Counts and verdict
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port master
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Reply watcher: oldest note against the reply cycle
  always @(posedge clk) rd_d <= rd && cen;
  always @(negedge clk) begin
    if (rd_d) check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bounded waits and period measurement
  task automatic wait_slp(input logic lvl);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (sleep_enable_bit === lvl) begin
        n_checks++;
        return;
      end
    end
    n_mismatch++;
    wrap_up();
  endtask
  task automatic rise(input bit p);
    int i;
    logic was;
    was = p ? pdc : sbc;
    for (i = 0; i < 5000; i++) begin
      @(posedge clk);
      #1;
      if ((p ? pdc : sbc) === 1'b1 && was === 1'b0) return;
      was = p ? pdc : sbc;
    end
    n_mismatch++;
    wrap_up();
  endtask
  // Skip one period for the ratio to settle, then time the next
  task automatic period(input bit p, input int n);
    int t0;
    rise(p);
    rise(p);
    t0 = cyc;
    rise(p);
    check(16'(cyc - t0), 16'(n));
  endtask
  task automatic pulse_irq;
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0; cen = 1'b1; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0; rd_d = 1'b0;
    osc_run = 1'b1; stop_lvl = 1'b0; attached = 1'b1; sync = 1'b1; pin_n = 1'b1; hold = 1'b0;
    irq = 1'b0; dram = 1'b0;
    void'($urandom(80255));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`SDC_MISC_ADDR, 8'h10);
    rd_reg(`SDC_SLEEP_ADDR, 8'h04);
    wr_reg(8'h20, 8'hff);
    rd_reg(8'h20, 8'h00);
    repeat (4) begin
      f = 2'($urandom % 3);
      s = 2'($urandom);
      b = 1'($urandom);
      wr_reg(`SDC_MISC_ADDR, {3'b000, f, b, s});
      rd_reg(`SDC_MISC_ADDR, {3'b000, f, b, s});
    end
    for (k = 0; k < 4; k++) begin
      wr_reg(`SDC_MISC_ADDR, {3'b000, 2'(k), 1'b1, 2'b11});
      period(0, (k == 3 ? 24 : (2 + 2 * k) * 4));
    end
    for (k = 0; k < 4; k++) begin
      wr_reg(`SDC_MISC_ADDR, {3'b000, 2'b00, 1'b0, 2'(k)});
      period(0, (2 + 2 * k) * 4);
    end
    wr_reg(`SDC_MISC_ADDR, 8'h07);
    dram <= 1'b1;
    period(0, 32);
    dram <= 1'b0;
    sync <= 1'b0;
    wr_reg(`SDC_MISC_ADDR, 8'h14);
    period(0, 36);
    sync <= 1'b1;
    // Oscillator removed: sense follows the resting pin
    b = 1'($urandom);
    attached <= 1'b0;
    osc_run <= 1'b0;
    stop_lvl <= b;
    repeat (6) @(posedge clk);
    wr_reg(`SDC_MISC_ADDR, {3'b000, 2'b10, ~b, 2'b00});
    rd_reg(`SDC_MISC_ADDR, {3'b000, 2'b10, b, 2'b00});
    attached <= 1'b1;
    osc_run <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(`SDC_MISC_ADDR, 8'h14);
    // Software sleep over the divider codes
    for (k = 0; k < 9; k++) begin
      wr_reg(`SDC_SLEEP_ADDR, {1'b1, 4'(k), 3'b000});
      wait_slp(1'b1);
      period(1, rt[k] * 4);
    end
    ne = 0;
    et = 0;
    pe = eso;
    repeat (24) begin
      @(posedge clk);
      #1;
      ne += neo;
      et += (eso !== pe);
      pe = eso;
    end
    check(16'(ne), 16'h0000);
    check(16'(et > 0), 16'h0001);
    // Clock enable low freezes the sleep state and the divided clock
    cen <= 1'b0;
    pe = pdc;
    repeat (12) @(posedge clk);
    cen <= 1'b1;
    check(16'({sleep_enable_bit, pdc}), {14'h0000, 1'b1, pe});
    hold <= 1'b1;
    wait_slp(1'b0);
    repeat (8) @(posedge clk);
    hold <= 1'b0;
    wait_slp(1'b1);
    hold <= 1'b1;
    wait_slp(1'b0);
    wr_reg(`SDC_SLEEP_ADDR, 8'h00);
    hold <= 1'b0;
    repeat (20) @(posedge clk);
    check(16'(sleep_enable_bit), 16'h0000);
    period(1, 4);
    // Interrupt ends sleep and it stays ended; bus idle as if halted
    wr_reg(`SDC_SLEEP_ADDR, 8'h80);
    wait_slp(1'b1);
    pulse_irq();
    wait_slp(1'b0);
    repeat (30) @(posedge clk);
    check(16'(sleep_enable_bit), 16'h0000);
    rd_reg(`SDC_SLEEP_ADDR, 8'h04);
    // Pin entry and exit
    wr_reg(`SDC_SLEEP_ADDR, 8'h02);
    pin_n <= 1'b0;
    wait_slp(1'b1);
    rd_reg(`SDC_SLEEP_ADDR, 8'h02);
    pin_n <= 1'b1;
    wait_slp(1'b0);
    wr_reg(`SDC_SLEEP_ADDR, 8'h03);
    pin_n <= 1'b0;
    wait_slp(1'b1);
    pin_n <= 1'b1;
    repeat (30) @(posedge clk);
    check(16'(sleep_enable_bit), 16'h0001);
    pulse_irq();
    wait_slp(1'b0);
    wr_reg(`SDC_SLEEP_ADDR, 8'h00);
    pin_n <= 1'b0;
    repeat (30) @(posedge clk);
    check(16'(sleep_enable_bit), 16'h0000);
    pin_n <= 1'b1;
    // Reset in mid-sleep
    wr_reg(`SDC_SLEEP_ADDR, 8'h80);
    wait_slp(1'b1);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    check(16'(sleep_enable_bit), 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`SDC_SLEEP_ADDR, 8'h04);
    rd_reg(`SDC_MISC_ADDR, 8'h10);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule // testbench
